/* hw/jtdr_pkg.sv */
// Purpose: Shared constants and types for the test data register block
// Assumes: CPU I/O bus with 6-bit addresses, 8-bit data
// Notes: Opcodes, field positions and register addresses live here only
package jtdr_pkg;
  localparam logic [3:0] OP_EXTEST = 4'h0;
  localparam logic [3:0] OP_IDCODE = 4'h1;
  localparam logic [3:0] OP_SAMPLE = 4'h2;
  localparam logic [3:0] OP_DBG_FIRST = 4'h8;
  localparam logic [3:0] OP_DBG_LAST = 4'hB;
  localparam logic [3:0] OP_CORE_RST = 4'hC;
  localparam logic [3:0] OP_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [5:0] CORE_CTRL_ADDR = 6'h35;
  localparam logic [5:0] STATUS_ADDR = 6'h34;
  localparam logic [5:0] DBG_MSG_ADDR = 6'h31;
  localparam logic [7:0] CTRL_RW_MASK = 8'h13;
  localparam int PDIS_BIT = 7;
  localparam int TRF_BIT = 4;
  localparam int DIRTY_BIT = 7;
  localparam logic [2:0] PDIS_WINDOW = 3'h4;
  localparam int ID_VER_LSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MAN_LSB = 1;
  localparam int DBG_LEN = 9;
  localparam int DBG_EN_BIT = 0;
  localparam int DBG_CLR_BIT = 1;
  localparam logic [15:0] TO_LAST = 16'h0001;
  typedef struct packed {
    logic tlr;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic capture_ir;
    logic shift_ir;
    logic update_ir;
  } jtdr_tap_s;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } jtdr_cpu_s;
  typedef enum logic [1:0] {RS_RUN, RS_HELD, RS_WAIT} jtdr_rst_e;
endpackage

/* hw/jtdr_top.sv */
// Purpose: Test data registers, instruction decode and debug message channel
// Assumes: TAP state strobes come from a TAP controller on tck_in
// Notes: CPU side runs on clk_in; scan side needs only tck_in
`timescale 1ns/1ps
module jtdr_top import jtdr_pkg::*; #(
  parameter int NPINS = 8,
  parameter int TO_BASE = 16,
  parameter bit MSG_SHARED = 1'b1,
  parameter logic [3:0] VERSION = 4'h0,
  parameter logic [15:0] PART_NUMBER = 16'h5A5A, // Arbitrary value
  parameter logic [10:0] MANUF_ID = 11'h2AA // Arbitrary value
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic tck_in,
  input wire logic tdi_in,
  input wire jtdr_tap_s tap_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  output logic port_en_out,
  input wire logic test_port_fuse_in,
  input wire logic debug_enable_fuse_in,
  input wire logic lock_bit_one_in,
  input wire logic lock_bit_two_in,
  input wire logic chip_erase_in,
  input wire logic fuse_prog_req_in,
  output logic fuse_prog_ok_out,
  output logic fuse_prog_refused_out,
  input wire logic [1:0] clk_opt_in,
  input wire jtdr_cpu_s cpu_in,
  input wire logic [7:0] alt_rdata_in,
  output logic alt_sel_out,
  output logic [7:0] cpu_rdata_out,
  input wire logic [NPINS-1:0] core_pin_out_in,
  input wire logic [NPINS-1:0] core_pin_oe_in,
  input wire logic [NPINS-1:0] pin_in,
  output logic [NPINS-1:0] pin_out,
  output logic [NPINS-1:0] pin_oe_out,
  output logic core_reset_out
);
  localparam int BSR_W = 3 * NPINS;

  // Refuse sizes the logic cannot serve
  if (NPINS < 1 || NPINS > 64) begin : g_bad_pins
    $error("NPINS out of range");
  end
  if (TO_BASE < 2 || TO_BASE > 8191) begin : g_bad_to
    $error("TO_BASE out of range");
  end

  //////////////////////////////////////////////////////////////////////
  // CPU side: core control register with timed disable bit

  logic pdis;
  logic pend;
  logic [2:0] win;
  logic [7:0] ctrl_rw;
  logic port_en;
  logic ocd_en;
  logic wr_ctrl;

  assign wr_ctrl = cpu_in.wr && cpu_in.addr == CORE_CTRL_ADDR;

  // Disable bit changes only on two equal writes inside the window
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pdis <= 1'b0;
      pend <= 1'b0;
      win <= '0;
    end else if (ce_in) begin
      if (wr_ctrl) begin
        if (win != '0 && pend == cpu_in.wdata[PDIS_BIT]) begin
          pdis <= pend;
          win <= '0;
        end else begin
          pend <= cpu_in.wdata[PDIS_BIT];
          win <= PDIS_WINDOW;
        end
      end else if (win != '0) begin
        win <= win - 3'h1;
      end
    end
  end

  // Control bits in CTRL_RW_MASK are plain storage; the other bits read zero, except bit 7, which reads the disable bit
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_rw <= '0;
    end else if (ce_in && wr_ctrl) begin
      ctrl_rw <= cpu_in.wdata & CTRL_RW_MASK;
    end
  end

  // No high-voltage pin exists: the four TAP pins are the whole path
  assign port_en = test_port_fuse_in && !pdis;
  // Debug system also dies when any lock bit is set
  assign ocd_en = port_en && debug_enable_fuse_in && !(lock_bit_one_in || lock_bit_two_in);
  assign port_en_out = port_en;

  //////////////////////////////////////////////////////////////////////
  // Debug fuse programming guard

  logic erased;

  // Erase memory lasts until system reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      erased <= 1'b0;
    end else if (ce_in && chip_erase_in) begin
      erased <= 1'b1;
    end
  end

  // Lock bits without a prior erase refuse the request
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fuse_prog_ok_out <= 1'b0;
      fuse_prog_refused_out <= 1'b0;
    end else if (ce_in) begin
      fuse_prog_ok_out <= fuse_prog_req_in && (erased || !(lock_bit_one_in || lock_bit_two_in));
      fuse_prog_refused_out <= fuse_prog_req_in && !erased && (lock_bit_one_in || lock_bit_two_in);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // CPU side: debug message register and crossings from the scan side

  logic [7:0] msg;
  logic dirty;
  logic [1:0] acc_s;
  logic [2:0] clr_s;
  logic clr_pulse;
  logic msg_sel;
  logic msg_hit;
  logic wr_msg;
  logic [7:0] msg_rd;
  logic clr_tgl;
  logic acc_en;

  // Level and toggle synchronisers from the test clock
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      acc_s <= '0;
      clr_s <= '0;
    end else if (ce_in) begin
      acc_s <= {acc_s[0], acc_en};
      clr_s <= {clr_s[1:0], clr_tgl};
    end
  end

  assign clr_pulse = clr_s[2] ^ clr_s[1];
  assign msg_hit = cpu_in.addr == DBG_MSG_ADDR;
  assign msg_sel = !MSG_SHARED || (ocd_en && acc_s[1]);
  assign wr_msg = cpu_in.wr && msg_hit && msg_sel;
  assign alt_sel_out = (cpu_in.wr || cpu_in.rd) && msg_hit && !msg_sel;
  assign msg_rd = {dirty, msg[DIRTY_BIT-1:0]};

  // Write sets dirty; a write beats a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      msg <= '0;
      dirty <= 1'b0;
    end else if (ce_in) begin
      if (wr_msg) begin
        msg <= cpu_in.wdata;
        dirty <= 1'b1;
      end else if (clr_pulse) begin
        dirty <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // CPU side: core reset sequencer and reset status flag

  logic [1:0] rc_s;
  logic rst_chain;
  logic [15:0] to_cnt;
  jtdr_rst_e rs;
  logic trf;
  logic [7:0] next_rdata;

  // Reset register level crosses into the chip clock
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rc_s <= '0;
    end else if (ce_in) begin
      rc_s <= {rc_s[0], rst_chain};
    end
  end

  // Held while the bit is one, then a fuse-chosen time-out
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rs <= RS_RUN;
      to_cnt <= '0;
    end else if (ce_in) begin
      case (rs)
        RS_RUN: begin
          if (rc_s[1]) begin
            rs <= RS_HELD;
          end
        end
        RS_HELD: begin
          if (!rc_s[1]) begin
            rs <= RS_WAIT;
            to_cnt <= 16'(TO_BASE) << clk_opt_in;
          end
        end
        RS_WAIT: begin
          if (rc_s[1]) begin
            rs <= RS_HELD;
          end else if (to_cnt == TO_LAST) begin
            rs <= RS_RUN;
          end else begin
            to_cnt <= to_cnt - TO_LAST;
          end
        end
        default: rs <= RS_RUN;
      endcase
    end
  end

  // Unlatched chain bit resets at once; sequencer covers the tail
  assign core_reset_out = rst_chain || rs != RS_RUN;

  // Set by test-port reset, cleared by zero write; set wins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      trf <= 1'b0;
    end else if (ce_in) begin
      if (rc_s[1]) begin
        trf <= 1'b1;
      end else if (cpu_in.wr && cpu_in.addr == STATUS_ADDR && !cpu_in.wdata[TRF_BIT]) begin
        trf <= 1'b0;
      end
    end
  end

  // Read mux; data returns one cycle after the strobe
  always_comb begin
    next_rdata = '0;
    case (cpu_in.addr)
      CORE_CTRL_ADDR: next_rdata = {pdis, ctrl_rw[PDIS_BIT-1:0]};
      STATUS_ADDR: next_rdata[TRF_BIT] = trf;
      DBG_MSG_ADDR: next_rdata = msg_sel ? msg_rd : alt_rdata_in;
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cpu_rdata_out <= '0;
    end else if (ce_in && cpu_in.rd) begin
      cpu_rdata_out <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Scan side: synchronisers and instruction register

  logic [3:0] t_s1;
  logic [3:0] t_s2;
  logic tck_rst;
  logic ocd_t;
  logic dirty_t;
  logic dirty_tq;
  logic [7:0] msg_t;
  logic [3:0] ir;
  logic [3:0] ir_sh;

  // Chip levels into the test clock; only stage two is read
  always_ff @(posedge tck_in) begin
    t_s1 <= {rst_in, port_en, ocd_en, dirty};
    t_s2 <= t_s1;
  end

  assign tck_rst = tap_in.tlr || t_s2[3] || !t_s2[2];
  assign ocd_t = t_s2[1];
  assign dirty_t = t_s2[0];

  // Message copied once dirty is seen; byte is stable by then
  always_ff @(posedge tck_in) begin
    if (tck_rst) begin
      dirty_tq <= 1'b0;
      msg_t <= '0;
    end else begin
      dirty_tq <= dirty_t;
      if (dirty_t && !dirty_tq) begin
        msg_t <= msg;
      end
    end
  end

  // Reset falls back to identification as the default
  always_ff @(posedge tck_in) begin
    if (tck_rst) begin
      ir <= OP_IDCODE;
      ir_sh <= IR_CAPTURE;
    end else if (tap_in.capture_ir) begin
      ir_sh <= IR_CAPTURE;
    end else if (tap_in.shift_ir) begin
      ir_sh <= {tdi_in, ir_sh[3:1]};
    end else if (tap_in.update_ir) begin
      ir <= ir_sh;
    end
  end

  logic sel_ext;
  logic sel_bsr;
  logic sel_id;
  logic sel_rst;
  logic sel_dbg;
  logic sel_byp;

  // Unknown opcodes and disabled debug opcodes fall to bypass
  assign sel_ext = ir == OP_EXTEST;
  assign sel_bsr = sel_ext || ir == OP_SAMPLE;
  assign sel_id = ir == OP_IDCODE;
  assign sel_rst = ir == OP_CORE_RST;
  assign sel_dbg = ocd_t && ir >= OP_DBG_FIRST && ir <= OP_DBG_LAST;
  assign sel_byp = !(sel_bsr || sel_id || sel_rst || sel_dbg);

  //////////////////////////////////////////////////////////////////////
  // Scan side: data registers

  logic [31:0] id_sh;
  logic byp;
  logic [DBG_LEN-1:0] dbg_sh;
  logic [BSR_W-1:0] bsr_sh;
  logic [2*NPINS-1:0] bsr_q;
  logic [NPINS-1:0] pin_s1;
  logic [NPINS-1:0] pin_s2;
  logic [31:0] id_word;

  assign id_word = {VERSION, PART_NUMBER, MANUF_ID, 1'b1};

  // Identification and bypass stages
  always_ff @(posedge tck_in) begin
    if (tck_rst) begin
      id_sh <= '0;
      byp <= 1'b0;
    end else if (tap_in.capture_dr) begin
      id_sh <= id_word;
      byp <= 1'b0;
    end else if (tap_in.shift_dr) begin
      if (sel_id) begin
        id_sh <= {tdi_in, id_sh[31:1]};
      end
      if (sel_byp) begin
        byp <= tdi_in;
      end
    end
  end

  // Reset chain: shifted only, TAP state is left alone
  always_ff @(posedge tck_in) begin
    if (tck_rst) begin
      rst_chain <= 1'b0;
    end else if (tap_in.shift_dr && sel_rst) begin
      rst_chain <= tdi_in;
    end
  end

  // Debug chain: capture {dirty, byte}, update sets access and clear
  always_ff @(posedge tck_in) begin
    if (tck_rst) begin
      dbg_sh <= '0;
      acc_en <= 1'b0;
      clr_tgl <= 1'b0;
    end else if (sel_dbg) begin
      if (tap_in.capture_dr) begin
        dbg_sh <= {dirty_t, msg_t};
      end else if (tap_in.shift_dr) begin
        dbg_sh <= {tdi_in, dbg_sh[DBG_LEN-1:1]};
      end else if (tap_in.update_dr) begin
        acc_en <= dbg_sh[DBG_EN_BIT];
        if (dbg_sh[DBG_CLR_BIT]) begin
          clr_tgl <= !clr_tgl;
        end
      end
    end
  end

  // Pin inputs pass two test-clock flops before capture
  always_ff @(posedge tck_in) begin
    pin_s1 <= pin_in;
    pin_s2 <= pin_s1;
  end

  // Boundary chain: capture never disturbs the pins
  always_ff @(posedge tck_in) begin
    if (tck_rst) begin
      bsr_sh <= '0;
      bsr_q <= '0;
    end else if (sel_bsr) begin
      if (tap_in.capture_dr) begin
        bsr_sh <= {core_pin_oe_in, core_pin_out_in, pin_s2};
      end else if (tap_in.shift_dr) begin
        bsr_sh <= {tdi_in, bsr_sh[BSR_W-1:1]};
      end else if (tap_in.update_dr) begin
        bsr_q <= bsr_sh[BSR_W-1:NPINS];
      end
    end
  end

  // Pin drive is combinational so EXTEST and reset act at once
  assign pin_out = sel_ext ? bsr_q[NPINS-1:0] : core_pin_out_in;
  assign pin_oe_out = sel_ext ? bsr_q[2*NPINS-1:NPINS] : (core_reset_out ? '0 : core_pin_oe_in);

  // Serial output changes on the falling test clock edge
  always_ff @(negedge tck_in) begin
    if (tck_rst) begin
      tdo_out <= 1'b0;
      tdo_oe_out <= 1'b0;
    end else begin
      tdo_oe_out <= tap_in.shift_ir || tap_in.shift_dr;
      if (tap_in.shift_ir) begin
        tdo_out <= ir_sh[0];
      end else if (sel_id) begin
        tdo_out <= id_sh[0];
      end else if (sel_bsr) begin
        tdo_out <= bsr_sh[0];
      end else if (sel_rst) begin
        tdo_out <= rst_chain;
      end else if (sel_dbg) begin
        tdo_out <= dbg_sh[0];
      end else begin
        tdo_out <= byp;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks

  a_port_off: assert property (@(posedge tck_in) disable iff (t_s2[3])
    !t_s2[2] |=> ir == OP_IDCODE && !tdo_oe_out) else $error("disabled port not held");
  a_fuse_refuse: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && fuse_prog_req_in && lock_bit_one_in && !erased |=> fuse_prog_refused_out && !fuse_prog_ok_out)
    else $error("debug fuse not refused");
  a_msg_write: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && wr_msg |=> dirty && msg == $past(cpu_in.wdata)) else $error("message write lost");
  a_msg_read: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && cpu_in.rd && msg_hit && msg_sel |=> cpu_rdata_out == $past(msg_rd)) else $error("bad message read");
  a_dirty_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && clr_pulse && !wr_msg |=> !dirty) else $error("dirty not cleared");
  a_shared_alt: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && cpu_in.wr && msg_hit && !msg_sel |-> alt_sel_out ##1 msg == $past(msg))
    else $error("shared address misrouted");
  a_id_default: assert property (@(posedge tck_in) disable iff (t_s2[3])
    tap_in.tlr |=> sel_id) else $error("default not identification");
  a_reset_hiz: assert property (@(posedge clk_in) disable iff (rst_in)
    core_reset_out && !sel_ext |-> pin_oe_out == '0) else $error("pins driven in reset");
  a_bypass_zero: assert property (@(posedge tck_in) disable iff (tck_rst)
    tap_in.capture_dr && sel_byp |=> !byp) else $error("bypass not zero");
  a_rst_immed: assert property (@(posedge tck_in) disable iff (tck_rst)
    tap_in.shift_dr && sel_rst && tdi_in |=> core_reset_out) else $error("reset not immediate");
  a_timeout_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && rs == RS_HELD && !rc_s[1] |=> core_reset_out [*2]) else $error("time-out skipped");
  a_trf_set: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && rc_s[1] |=> trf) else $error("reset flag not set");

  c_extest: cover property (@(posedge tck_in) disable iff (tck_rst) $rose(sel_ext));
  c_dirty_clear: cover property (@(posedge clk_in) disable iff (rst_in) dirty ##1 !dirty);
  c_timeout_end: cover property (@(posedge clk_in) disable iff (rst_in) rs == RS_WAIT ##1 rs == RS_RUN);
endmodule

/* testbench/jtag_test_data_registers_tb.sv */
// Purpose: Self-checking bench for the test data register block
// Assumes: Controller model drives the scan port, bench drives the CPU side
// Notes: Small reset time-out base keeps the run short
`timescale 1ns/1ps
module jtag_test_data_registers_tb import jtdr_pkg::*; ;
  localparam logic [3:0] VER = 4'h3;
  localparam logic [15:0] PART = 16'hC3A5; // Arbitrary value
  localparam logic [10:0] MANUF = 11'h155; // Arbitrary value
  localparam int TOB = 4;
  logic clk, rst, tck, tdi, tdo, port_en, ok, refused, alt_sel, core_reset;
  logic tdo_oe, tdo_pin, ce;
  logic fuse_port, fuse_dbg, lb1, lb2, erase, fuse_req, rd_d;
  logic [1:0] clk_opt;
  jtdr_tap_s tap;
  jtdr_cpu_s cpu;
  logic [7:0] alt_rdata, cpu_rdata, pin_in, pin_out, pin_oe, core_out, core_oe, d;
  logic [63:0] dv;
  logic [7:0] exp_q[$];
  int errors, num_checks, cycles, n, to;
  logic [3:0] byp_ops[12] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hD, 4'hE, 4'hF, 4'h8, 4'h9, 4'hA, 4'hB};
  logic [2:0] fz[4] = '{3'h1, 3'h4, 3'h2, 3'h7};
  jtdr_top #(.NPINS(8), .TO_BASE(TOB), .VERSION(VER), .PART_NUMBER(PART), .MANUF_ID(MANUF)) dut (
    .clk_in(clk), .rst_in(rst), .ce_in(ce), .tck_in(tck), .tdi_in(tdi), .tap_in(tap),
    .tdo_out(tdo), .tdo_oe_out(tdo_oe), .port_en_out(port_en), .test_port_fuse_in(fuse_port),
    .debug_enable_fuse_in(fuse_dbg), .lock_bit_one_in(lb1), .lock_bit_two_in(lb2),
    .chip_erase_in(erase), .fuse_prog_req_in(fuse_req), .fuse_prog_ok_out(ok),
    .fuse_prog_refused_out(refused), .clk_opt_in(clk_opt), .cpu_in(cpu), .alt_rdata_in(alt_rdata),
    .alt_sel_out(alt_sel), .cpu_rdata_out(cpu_rdata), .core_pin_out_in(core_out),
    .core_pin_oe_in(core_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe),
    .core_reset_out(core_reset));
  // Released TDO shows the inverse of its last value, so stale data cannot pass
  assign tdo_pin = tdo_oe ? tdo : ~tdo;
  jtdr_ctl_model u_ctl (.tck_out(tck), .tdi_out(tdi), .tap_out(tap), .tdo_in(tdo_pin));
  ////////////////////////////////////////////////////////////////////////
  // Chip clock, 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Write held for cnt cycles; two cycles give the doubled write
  task automatic cpu_wr(input logic [5:0] a, input logic [7:0] v, input int cnt);
    cpu.wr = 1'b1;
    cpu.addr = a;
    cpu.wdata = v;
    repeat (cnt) @(negedge clk);
    cpu.wr = 1'b0;
    @(negedge clk);
  endtask
  // Read with the expected byte noted for the monitor
  task automatic cpu_rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    cpu.rd = 1'b1;
    cpu.addr = a;
    @(negedge clk);
    cpu.rd = 1'b0;
    @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Monitor: read data appears the cycle after the read edge
  always @(posedge clk) rd_d <= cpu.rd;
  always @(negedge clk) begin
    if (rd_d === 1'b1) begin
      check("cpu_rdata", cpu_rdata, exp_q.pop_front());
    end
  end
  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h71A6));
    {rst, fuse_dbg, lb1, lb2, erase, fuse_req} = 6'h20;
    fuse_port = 1'b1;
    cpu = '0;
    ce = 1'b1;
    clk_opt = 2'($urandom_range(3, 0));
    to = TOB << clk_opt;
    alt_rdata = 8'($urandom);
    pin_in = 8'($urandom);
    core_out = 8'($urandom);
    core_oe = 8'($urandom) | 8'h81;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    u_ctl.tlr_reset();
    fork
      u_ctl.scan_dr(32, '1, 1'b1, dv);
      #100 check("tdo_oe", tdo_oe, 1'b1);
    join
    check("idcode", dv[31:0], {VER, PART, MANUF, 1'b1});
    // Unused and fuse-disabled debug opcodes must all fall back to bypass
    foreach (byp_ops[k]) begin
      u_ctl.load_ir(byp_ops[k]);
      u_ctl.scan_dr(3, 64'h5, 1'b1, dv);
      check("bypass", dv[2:0], 3'h2);
    end
    @(negedge clk);
    d = 8'($urandom);
    cpu_wr(DBG_MSG_ADDR, d, 1);
    fork
      cpu_rd(DBG_MSG_ADDR, alt_rdata);
      #1 check("alt_sel", alt_sel, 1'b1);
    join
    fuse_dbg = 1'b1;
    u_ctl.load_ir(OP_DBG_FIRST);
    u_ctl.scan_dr(9, 64'h1, 1'b1, dv);
    check("dbg_capture", dv[8:0], 9'h000);
    repeat (8) @(negedge clk);
    cpu_wr(DBG_MSG_ADDR, d, 1);
    fork
      cpu_rd(DBG_MSG_ADDR, {1'b1, d[6:0]});
      #1 check("alt_sel", alt_sel, 1'b0);
    join
    repeat (4) @(negedge clk);
    u_ctl.idle(3);
    u_ctl.scan_dr(9, 64'h3, 1'b1, dv);
    check("dbg_msg", dv[8:0], {1'b1, d});
    repeat (8) @(negedge clk);
    cpu_rd(DBG_MSG_ADDR, {1'b0, d[6:0]});
    for (int op = 8; op < 12; op++) begin
      u_ctl.load_ir(4'(op));
      u_ctl.scan_dr(9, 64'h1, 1'b1, dv);
      check("dbg_chain", dv[8:0], {1'b0, d});
    end
    @(negedge clk);
    cpu_wr(CORE_CTRL_ADDR, 8'h80, 1);
    check("port_en", port_en, 1'b1);
    cpu_wr(CORE_CTRL_ADDR, 8'h80, 2);
    check("port_en", port_en, 1'b0);
    cpu_rd(CORE_CTRL_ADDR, 8'h80);
    cpu_wr(CORE_CTRL_ADDR, 8'h00, 2);
    check("port_en", port_en, 1'b1);
    fuse_port = 1'b0;
    #1 check("port_en", port_en, 1'b0);
    // Disabled port keeps the scan side in reset and TDO released
    u_ctl.idle(3);
    u_ctl.scan_dr(32, '0, 1'b1, dv);
    check("port_off", dv[31:0], 32'hFFFF_FFFF);
    @(negedge clk);
    fuse_port = 1'b1;
    u_ctl.tlr_reset();
    u_ctl.load_ir(OP_CORE_RST);
    u_ctl.scan_dr(1, 64'h1, 1'b0, dv);
    check("core_reset", core_reset, 1'b1);
    check("pin_oe", pin_oe, 8'h00);
    u_ctl.scan_dr(1, 64'h0, 1'b0, dv);
    n = 0;
    while (core_reset === 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check("timeout", 32'(n >= to - 1 && n <= to + 4), 1);
    @(negedge clk);
    cpu_rd(STATUS_ADDR, 8'h10);
    cpu_wr(STATUS_ADDR, 8'h00, 1);
    cpu_rd(STATUS_ADDR, 8'h00);
    // Clock enable low: a doubled disable write must not land
    ce = 1'b0;
    cpu_wr(CORE_CTRL_ADDR, 8'h80, 2);
    check("port_en", port_en, 1'b1);
    ce = 1'b1;
    // Preload safe values before the first external test
    d = 8'($urandom);
    u_ctl.load_ir(OP_SAMPLE);
    u_ctl.scan_dr(24, {40'h0, 8'hFF, d, 8'h00}, 1'b1, dv);
    check("snapshot", dv[7:0], pin_in);
    check("pins", {pin_oe, pin_out}, {core_oe, core_out});
    u_ctl.load_ir(OP_EXTEST);
    check("extest", {pin_oe, pin_out}, {8'hFF, d});
    @(negedge clk);
    foreach (fz[k]) begin
      if (k == 3) begin
        erase = 1'b1;
        @(negedge clk);
        erase = 1'b0;
        @(negedge clk);
      end
      lb1 = fz[k][2];
      lb2 = fz[k][1];
      fuse_req = 1'b1;
      @(negedge clk);
      fuse_req = 1'b0;
      check("prog_ok", ok, fz[k][0]);
      check("prog_refused", refused, !fz[k][0]);
      @(negedge clk);
    end
    results();
  end
endmodule

/* testbench/jtdr_ctl_model.sv */
// Purpose: Behavioural test controller driving the scan port
// Assumes: Test clock idles high and runs only inside frames
// Notes: Signals change 2 ns after a rising edge, TDO sampled just before it
`timescale 1ns/1ps
module jtdr_ctl_model import jtdr_pkg::*; (
  output logic tck_out,
  output logic tdi_out,
  output jtdr_tap_s tap_out,
  input wire logic tdo_in
);
  localparam jtdr_tap_s S_TLR = 7'h40;
  localparam jtdr_tap_s S_CDR = 7'h20;
  localparam jtdr_tap_s S_SDR = 7'h10;
  localparam jtdr_tap_s S_UDR = 7'h08;
  localparam jtdr_tap_s S_CIR = 7'h04;
  localparam jtdr_tap_s S_SIR = 7'h02;
  localparam jtdr_tap_s S_UIR = 7'h01;
  // Idle: clock stopped high, data line at its pull-up level
  initial begin
    tck_out = 1'b1;
    tdi_out = 1'b1;
    tap_out = '0;
  end
  ////////////////////////////////////////////////////////////////////////
  // One test clock period; falling edge first so TDO settles before the rise
  task automatic cyc(input jtdr_tap_s st, input logic dbit, output logic q);
    #2;
    tap_out = st;
    tdi_out = dbit;
    #22 tck_out = 1'b0;
    #23 q = tdo_in;
    #1 tck_out = 1'b1;
  endtask
  // Hold the reset state long enough for the port synchronisers
  task automatic tlr_reset();
    logic q;
    repeat (4) cyc(S_TLR, 1'b1, q);
    cyc('0, 1'b1, q);
  endtask
  // Clock in Run-Test/Idle so chip-side levels reach the scan side
  task automatic idle(input int n);
    logic q;
    repeat (n) cyc('0, 1'b1, q);
  endtask
  // Instruction scan, LSB first
  task automatic load_ir(input logic [3:0] op);
    logic q;
    cyc(S_CIR, 1'b1, q);
    for (int i = 0; i < 4; i++) begin
      cyc(S_SIR, op[i], q);
    end
    cyc(S_UIR, 1'b1, q);
    cyc('0, 1'b1, q);
  endtask
  // Data scan; without update it leaves with no Update-DR strobe, straight to idle
  task automatic scan_dr(input int n, input logic [63:0] din, input logic upd, output logic [63:0] dout);
    logic q;
    dout = '0;
    cyc(S_CDR, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      cyc(S_SDR, din[i], q);
      dout[i] = q;
    end
    if (upd) begin
      cyc(S_UDR, 1'b1, q);
    end
    cyc('0, 1'b1, q);
  endtask
endmodule
